// *** gdl_params.svh ***
// Constants shared by both ends of the gate drive lockout link
`ifndef GDL_PARAMS_SVH
`define GDL_PARAMS_SVH

`define GDL_CLK_PERIOD_NS 4
`define GDL_T_EN_TO_LS_NS 280
`define GDL_T_MIN_PULSE_NS 100
`define GDL_T_BOOT_CHARGE_NS 1000
`define GDL_T_POWER_UP_NS 2000000
`define GDL_EN_TO_LS_CYC ((`GDL_T_EN_TO_LS_NS + `GDL_CLK_PERIOD_NS - 1) / `GDL_CLK_PERIOD_NS)
`define GDL_MIN_PULSE_CYC ((`GDL_T_MIN_PULSE_NS + `GDL_CLK_PERIOD_NS - 1) / `GDL_CLK_PERIOD_NS)
`define GDL_BOOT_CHARGE_CYC ((`GDL_T_BOOT_CHARGE_NS + `GDL_CLK_PERIOD_NS - 1) / `GDL_CLK_PERIOD_NS)
`define GDL_POWER_UP_CYC ((`GDL_T_POWER_UP_NS + `GDL_CLK_PERIOD_NS - 1) / `GDL_CLK_PERIOD_NS)

// Command bytes
`define GDL_CMD_STATUS_0 8'h00
`define GDL_CMD_STATUS_1 8'h01
`define GDL_CMD_CLEAR_INT_0 8'h6C
`define GDL_CMD_CLEAR_INT_1 8'h6D
`define GDL_CMD_DEAD_ZERO 8'h80
`define GDL_CMD_DEAD_CAL 8'h81
`define GDL_CMD_MASK_LO_HI 4'h2
`define GDL_CMD_MASK_HI_HI 4'h3
`define GDL_CMD_MODE_HI 3'h2
`define GDL_MODE_LOCK_BIT 0

// Interrupt flag positions
`define GDL_FLAG_FAULT 0
`define GDL_FLAG_LOCKOUT 1

// Controller register offsets and fields
`define GDL_REG_CTRL 4'h0
`define GDL_REG_CFG 4'h4
`define GDL_REG_STATUS 4'h8
`define GDL_CTRL_FULL_INIT 0
`define GDL_CTRL_RECOVER 1
`define GDL_CTRL_STANDBY 2
`define GDL_CFG_RESET 32'h1910_00F0

`endif

// *** gdl_pkg.sv ***
// Types shared by the gate drive lockout device and controller
package gdl_pkg;
   typedef enum logic [1:0] {
      GDL_DEV_OFF,
      GDL_DEV_POWERUP,
      GDL_DEV_STANDBY,
      GDL_DEV_RUN
   } gdl_dev_state_type;

   typedef enum logic [3:0] {
      GDL_CTL_IDLE,
      GDL_CTL_PU_WAIT,
      GDL_CTL_SEND,
      GDL_CTL_EN_WAIT,
      GDL_CTL_HS_SET,
      GDL_CTL_LS_ON,
      GDL_CTL_LS_OFF,
      GDL_CTL_HS_ON,
      GDL_CTL_HS_OFF
   } gdl_ctl_state_type;

   typedef logic [7:0] gdl_byte_type;
   typedef logic [2:0] gdl_phase_type;
endpackage : gdl_pkg

// *** gdl_link_if.sv ***
// Pin level link between the microcontroller end and the pre-driver end
interface gdl_link_if;
   logic reset_input_n;
   logic enable_input_one;
   logic enable_input_two;
   logic phase_a_low_side_input;
   logic phase_b_low_side_input;
   logic phase_c_low_side_input;
   logic phase_a_high_side_input_n;
   logic phase_b_high_side_input_n;
   logic phase_c_high_side_input_n;
   logic cmd_valid;
   logic [7:0] cmd;
   logic [7:0] resp;
   logic irq;

   modport dev (
      input reset_input_n, enable_input_one, enable_input_two,
      input phase_a_low_side_input, phase_b_low_side_input, phase_c_low_side_input,
      input phase_a_high_side_input_n, phase_b_high_side_input_n, phase_c_high_side_input_n,
      input cmd_valid, cmd,
      output resp, irq
   );

   modport ctl (
      output reset_input_n, enable_input_one, enable_input_two,
      output phase_a_low_side_input, phase_b_low_side_input, phase_c_low_side_input,
      output phase_a_high_side_input_n, phase_b_high_side_input_n, phase_c_high_side_input_n,
      output cmd_valid, cmd,
      input resp, irq
   );
endinterface : gdl_link_if

// *** gdl_dev.sv ***
// Pre-driver control end: standby, fault lockout, init sequence and command port
`include "gdl_params.svh"

// Functional notes
// RULE1: Standby or fault: gates low, high side locked.
// RULE2: Recovery low side pulse may be 100 ns.
// RULE3: Recovery starts with clear-interrupt commands.
// RULE4: Outputs respond only with both enables high.
// RULE5: Low side pulse lasts at least 100 ns.
// RULE6: High side low for dead time plus 100 ns.
// RULE7: All high sides on gives recirculation, no motion.
// RULE8: Toggle end restores drive, gates shorted, off.
// RULE9: Inputs edge sensitive; early high edge stays locked.
// RULE10: First low side rise after both enables.
// RULE11: Wait 280 ns after enables before low side.
// RULE12: Each phase accepts separate or tied inputs.
// RULE13: Reset rise powers up, starts configured pump.
// RULE14: Power-up clears flags with both clear commands.
// RULE15: Mask command upper nibble 0010 or 0011.
// RULE16: Dead time zeroed or calibrated before enabling.
// RULE17: Lock bit freezes mode against later changes.
// RULE18: Ordered high/low side sequence after enables.
// RULE19: Low side on when input is one.
// RULE20: High side on when input is zero.
// RULE21: Command answer returns in the next transfer.
// RULE22: Interrupt: query both status, act, then clear.
module gdl_dev #(
   parameter int POWER_UP_CYC = `GDL_POWER_UP_CYC,
   parameter int WAKE_CYC = `GDL_EN_TO_LS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   gdl_link_if.dev link,
   input wire logic fault,
   input wire gdl_pkg::gdl_phase_type tied_mode,
   input wire logic pump_configured,
   output gdl_pkg::gdl_phase_type low_side_gate,
   output gdl_pkg::gdl_phase_type high_side_gate,
   output gdl_pkg::gdl_phase_type gate_source_short,
   output gdl_pkg::gdl_phase_type high_side_locked,
   output logic recirculation,
   output logic charge_pump_on,
   output logic supplies_ready
);
   import gdl_pkg::*;

   initial begin
      if (POWER_UP_CYC < 1 || POWER_UP_CYC > 1048575 || WAKE_CYC < 1 || WAKE_CYC > 1048575) begin
         $error("gdl_dev: count parameter out of range");
      end
   end

   gdl_dev_state_type state;
   gdl_dev_state_type next_state;
   logic [19:0] count;
   logic [19:0] next_count;
   gdl_phase_type ls_prev;
   gdl_phase_type hs_n_prev;
   gdl_phase_type armed;
   gdl_phase_type toggling;
   logic [3:0] flags;
   logic [7:0] mask;
   logic [4:0] mode;
   logic mode_locked;
   logic dead_cal;

   wire enables_high = link.enable_input_one & link.enable_input_two;
   wire running = (state == GDL_DEV_RUN) & ~fault;
   wire gdl_phase_type ls_in = {link.phase_c_low_side_input, link.phase_b_low_side_input,
                                link.phase_a_low_side_input};
   wire gdl_phase_type hs_n_pin = {link.phase_c_high_side_input_n,
                                   link.phase_b_high_side_input_n,
                                   link.phase_a_high_side_input_n};
   // A tied phase sees one level: 1 is low side on, 0 is high side on
   wire gdl_phase_type hs_n_in = (tied_mode & ls_in) | (~tied_mode & hs_n_pin); // [RULE12]
   wire gdl_phase_type ls_eff = ls_in & ~tied_mode | ls_in & tied_mode;
   wire gdl_phase_type ls_rise = ls_eff & ~ls_prev; // [RULE9]
   wire gdl_phase_type hs_fall = ~hs_n_in & hs_n_prev; // [RULE9]
   wire gdl_phase_type hs_rise = hs_n_in & ~hs_n_prev;

   // Command decode
   wire cmd_clear0 = link.cmd_valid & (link.cmd == `GDL_CMD_CLEAR_INT_0);
   wire cmd_clear1 = link.cmd_valid & (link.cmd == `GDL_CMD_CLEAR_INT_1);
   wire cmd_mask_lo = link.cmd_valid & (link.cmd[7:4] == `GDL_CMD_MASK_LO_HI);
   wire cmd_mask_hi = link.cmd_valid & (link.cmd[7:4] == `GDL_CMD_MASK_HI_HI);
   wire cmd_mode = link.cmd_valid & (link.cmd[7:5] == `GDL_CMD_MODE_HI);
   wire cmd_dead_zero = link.cmd_valid & (link.cmd == `GDL_CMD_DEAD_ZERO);
   wire cmd_dead_cal = link.cmd_valid & (link.cmd == `GDL_CMD_DEAD_CAL);
   wire cmd_status1 = link.cmd_valid & (link.cmd == `GDL_CMD_STATUS_1);
   wire [7:0] answer = cmd_status1 ? {mode_locked, dead_cal, 1'b0, mode} :
                       {mask[3:0], flags};
   wire lockout_event = |(hs_fall & high_side_locked & ~armed) & running;
   wire [3:0] flag_set = {2'b00, lockout_event, fault};
   wire [3:0] flag_clr = {cmd_clear1, cmd_clear1, cmd_clear0, cmd_clear0};

   // Power up, standby and wake sequencing
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         GDL_DEV_OFF: begin
            if (link.reset_input_n && !enables_high) begin
               next_state = GDL_DEV_POWERUP; // [RULE13]
               next_count = 20'(POWER_UP_CYC - 1);
            end
         end
         GDL_DEV_POWERUP: begin
            if (count == 20'h0_0000) begin
               next_state = GDL_DEV_STANDBY;
            end else begin
               next_count = count - 20'h0_0001;
            end
         end
         GDL_DEV_STANDBY: begin
            if (!enables_high) begin
               next_count = 20'(WAKE_CYC - 1);
            end else if (count == 20'h0_0000) begin
               next_state = GDL_DEV_RUN; // [RULE11]
            end else begin
               next_count = count - 20'h0_0001;
            end
         end
         GDL_DEV_RUN: begin
            if (!enables_high) begin
               next_state = GDL_DEV_STANDBY; // [RULE1]
               next_count = 20'(WAKE_CYC - 1);
            end
         end
         default: begin
            next_state = GDL_DEV_OFF;
         end
      endcase
      if (!link.reset_input_n) begin
         next_state = GDL_DEV_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= GDL_DEV_OFF;
         count <= 20'h0_0000;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Per phase lockout and gate drive
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ls_prev[p] <= 1'b0;
               hs_n_prev[p] <= 1'b1;
               armed[p] <= 1'b0;
               toggling[p] <= 1'b0;
               high_side_locked[p] <= 1'b1;
               low_side_gate[p] <= 1'b0;
               high_side_gate[p] <= 1'b0;
               gate_source_short[p] <= 1'b0;
            end else begin
               ls_prev[p] <= ls_eff[p];
               hs_n_prev[p] <= hs_n_in[p];
               if (!running) begin
                  armed[p] <= 1'b0; // [RULE1]
                  toggling[p] <= 1'b0;
                  high_side_locked[p] <= 1'b1;
               end else if (high_side_locked[p]) begin
                  if (ls_rise[p]) begin
                     armed[p] <= 1'b1; // [RULE9] [RULE10]
                  end
                  if (armed[p] && hs_fall[p]) begin
                     toggling[p] <= 1'b1;
                  end
                  if (toggling[p] && hs_rise[p]) begin
                     toggling[p] <= 1'b0; // [RULE8]
                     armed[p] <= 1'b0;
                     high_side_locked[p] <= 1'b0;
                  end
               end
               // Both enables high and the device running, else all gates low
               low_side_gate[p] <= running & ls_eff[p] & hs_n_in[p]; // [RULE4] [RULE19]
               high_side_gate[p] <= running & ~hs_n_in[p] &
                                    (~high_side_locked[p] | toggling[p]); // [RULE20] [RULE7]
               gate_source_short[p] <= running & hs_n_in[p] &
                                       (~high_side_locked[p] | toggling[p]); // [RULE8]
            end
         end
      end
   endgenerate

   // Command port, interrupt flags and configuration
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags <= 4'h0;
         mask <= 8'h00;
         mode <= 5'h00;
         mode_locked <= 1'b0;
         dead_cal <= 1'b0;
         link.resp <= 8'h00;
         link.irq <= 1'b0;
         recirculation <= 1'b0;
         charge_pump_on <= 1'b0;
         supplies_ready <= 1'b0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set; // [RULE14]
         if (cmd_mask_lo) begin
            mask[3:0] <= link.cmd[3:0]; // [RULE15]
         end
         if (cmd_mask_hi) begin
            mask[7:4] <= link.cmd[3:0];
         end
         if (cmd_mode && !mode_locked) begin
            mode <= link.cmd[4:0];
            mode_locked <= link.cmd[`GDL_MODE_LOCK_BIT]; // [RULE17]
         end
         if (cmd_dead_zero) begin
            dead_cal <= 1'b0; // [RULE16]
         end else if (cmd_dead_cal) begin
            dead_cal <= 1'b1;
         end
         if (link.cmd_valid) begin
            link.resp <= answer; // [RULE21]
         end
         link.irq <= |(((flags & ~flag_clr) | flag_set) & ~mask[3:0]); // [RULE22]
         recirculation <= running & (~|hs_n_in) & ~(|high_side_locked & ~(|toggling)); // [RULE7]
         charge_pump_on <= pump_configured & (next_state != GDL_DEV_OFF); // [RULE13]
         supplies_ready <= (next_state == GDL_DEV_STANDBY) | (next_state == GDL_DEV_RUN);
      end
   end

endmodule : gdl_dev

// *** gdl_ctl.sv ***
// Microcontroller end: runs power-up, recovery and interrupt service sequences
`include "gdl_params.svh"

module gdl_ctl #(
   parameter int POWER_UP_CYC = `GDL_POWER_UP_CYC,
   parameter int WAKE_CYC = `GDL_EN_TO_LS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   gdl_link_if.ctl link,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   import gdl_pkg::*;

   initial begin
      if (POWER_UP_CYC < 1 || POWER_UP_CYC > 1048575 || WAKE_CYC < 1 || WAKE_CYC > 1048575) begin
         $error("gdl_ctl: count parameter out of range");
      end
   end

   gdl_ctl_state_type state;
   logic [19:0] count;
   logic [3:0] idx;
   logic [3:0] last_idx;
   logic [31:0] cfg;
   logic busy;
   logic ready;
   logic irq_seen;
   logic [7:0] stat0;
   logic [7:0] stat1;
   logic [3:0] prev_idx;
   logic prev_valid;

   wire ctrl_wr = wr & (addr == `GDL_REG_CTRL);
   wire start_full = ctrl_wr & wdata[`GDL_CTRL_FULL_INIT] & ~busy;
   wire start_rec = ctrl_wr & wdata[`GDL_CTRL_RECOVER] & ~busy;
   wire go_standby = ctrl_wr & wdata[`GDL_CTRL_STANDBY] & ~busy;
   wire [7:0] ls_cyc = (cfg[23:16] < 8'(`GDL_MIN_PULSE_CYC)) ? 8'(`GDL_MIN_PULSE_CYC) :
                       cfg[23:16]; // [RULE5] [RULE2]
   wire [19:0] hs_cyc = 20'(cfg[31:24]) + 20'(`GDL_MIN_PULSE_CYC); // [RULE6]
   wire service = (state == GDL_CTL_IDLE) & link.irq & ready & ~start_full & ~start_rec;
   // Command list: 0-4 setup, 5-8 interrupt service
   wire [7:0] cmd_of [0:8];
   assign cmd_of[0] = `GDL_CMD_CLEAR_INT_0; // [RULE14] [RULE3]
   assign cmd_of[1] = `GDL_CMD_CLEAR_INT_1;
   assign cmd_of[2] = {`GDL_CMD_MASK_LO_HI, cfg[3:0]}; // [RULE15]
   assign cmd_of[3] = cfg[8] ? `GDL_CMD_DEAD_CAL : `GDL_CMD_DEAD_ZERO; // [RULE16]
   assign cmd_of[4] = {`GDL_CMD_MODE_HI, cfg[7:4], 1'b1}; // [RULE17]
   assign cmd_of[5] = `GDL_CMD_STATUS_0; // [RULE22]
   assign cmd_of[6] = `GDL_CMD_STATUS_1;
   assign cmd_of[7] = `GDL_CMD_CLEAR_INT_0;
   assign cmd_of[8] = `GDL_CMD_CLEAR_INT_1;
   wire [31:0] status_word = {8'h00, stat1, stat0, 5'h00, irq_seen, ready, busy};
   wire [31:0] read_mux = (addr == `GDL_REG_CTRL) ? 32'h0000_0000 :
                          (addr == `GDL_REG_CFG) ? cfg :
                          (addr == `GDL_REG_STATUS) ? status_word : 32'h0000_0000;
   wire [2:0] all_hs = {3{link.phase_a_high_side_input_n}};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
         cfg <= `GDL_CFG_RESET;
      end else begin
         rdata <= rd ? read_mux : 32'h0000_0000;
         if (wr && addr == `GDL_REG_CFG) begin
            cfg <= wdata;
         end
      end
   end

   // Answers come one transfer late, so pair them with the previous command
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_idx <= 4'h0;
         prev_valid <= 1'b0;
         stat0 <= 8'h00;
         stat1 <= 8'h00;
      end else if (link.cmd_valid) begin
         prev_idx <= idx - 4'h1;
         prev_valid <= 1'b1;
         if (prev_valid && prev_idx == 4'h5) begin
            stat0 <= link.resp; // [RULE21]
         end
         if (prev_valid && prev_idx == 4'h6) begin
            stat1 <= link.resp;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= GDL_CTL_IDLE;
         count <= 20'h0_0000;
         idx <= 4'h0;
         last_idx <= 4'h0;
         busy <= 1'b0;
         ready <= 1'b0;
         irq_seen <= 1'b0;
         link.reset_input_n <= 1'b0;
         link.enable_input_one <= 1'b0;
         link.enable_input_two <= 1'b0;
         link.phase_a_low_side_input <= 1'b0;
         link.phase_b_low_side_input <= 1'b0;
         link.phase_c_low_side_input <= 1'b0;
         link.phase_a_high_side_input_n <= 1'b1;
         link.phase_b_high_side_input_n <= 1'b1;
         link.phase_c_high_side_input_n <= 1'b1;
         link.cmd_valid <= 1'b0;
         link.cmd <= 8'h00;
      end else begin
         link.cmd_valid <= 1'b0;
         if (count != 20'h0_0000) begin
            count <= count - 20'h0_0001;
         end
         case (state)
            GDL_CTL_IDLE: begin
               if (start_full) begin
                  busy <= 1'b1;
                  ready <= 1'b0;
                  link.reset_input_n <= 1'b1; // [RULE13]
                  link.enable_input_one <= 1'b0;
                  link.enable_input_two <= 1'b0;
                  count <= 20'(POWER_UP_CYC);
                  idx <= 4'h0;
                  last_idx <= 4'h4;
                  state <= GDL_CTL_PU_WAIT;
               end else if (start_rec) begin
                  busy <= 1'b1;
                  link.enable_input_one <= 1'b0;
                  link.enable_input_two <= 1'b0;
                  idx <= 4'h0;
                  last_idx <= 4'h1; // [RULE3]
                  state <= GDL_CTL_SEND;
               end else if (go_standby) begin
                  link.enable_input_one <= 1'b0;
                  link.enable_input_two <= 1'b0;
               end else if (service) begin
                  busy <= 1'b1;
                  irq_seen <= 1'b1;
                  idx <= 4'h5;
                  last_idx <= 4'h8; // [RULE22]
                  state <= GDL_CTL_SEND;
               end
            end
            GDL_CTL_PU_WAIT: begin
               if (count == 20'h0_0000) begin
                  state <= GDL_CTL_SEND;
               end
            end
            GDL_CTL_SEND: begin
               // Enables rise only after the last command has gone out
               if (idx == last_idx + 4'h1) begin
                  if (last_idx == 4'h8) begin
                     busy <= 1'b0;
                     state <= GDL_CTL_IDLE;
                  end else begin
                     link.enable_input_one <= 1'b1; // [RULE4] [RULE18] [RULE3]
                     link.enable_input_two <= 1'b1;
                     count <= 20'(WAKE_CYC);
                     state <= GDL_CTL_EN_WAIT;
                  end
               end else if (!link.cmd_valid) begin
                  link.cmd_valid <= 1'b1;
                  link.cmd <= cmd_of[idx];
                  idx <= idx + 4'h1;
               end
            end
            GDL_CTL_EN_WAIT: begin
               if (count == 20'h0_0000) begin
                  link.phase_a_high_side_input_n <= 1'b1; // [RULE18]
                  link.phase_b_high_side_input_n <= 1'b1;
                  link.phase_c_high_side_input_n <= 1'b1;
                  state <= GDL_CTL_HS_SET;
               end
            end
            GDL_CTL_HS_SET: begin
               link.phase_a_low_side_input <= 1'b1; // [RULE10] [RULE11] [RULE5]
               link.phase_b_low_side_input <= 1'b1;
               link.phase_c_low_side_input <= 1'b1;
               count <= 20'(ls_cyc) - 20'h0_0001;
               state <= GDL_CTL_LS_ON;
            end
            GDL_CTL_LS_ON: begin
               if (count == 20'h0_0000) begin
                  link.phase_a_low_side_input <= 1'b0;
                  link.phase_b_low_side_input <= 1'b0;
                  link.phase_c_low_side_input <= 1'b0;
                  state <= GDL_CTL_LS_OFF;
               end
            end
            GDL_CTL_LS_OFF: begin
               link.phase_a_high_side_input_n <= 1'b0; // [RULE6] [RULE7]
               link.phase_b_high_side_input_n <= 1'b0;
               link.phase_c_high_side_input_n <= 1'b0;
               count <= hs_cyc - 20'h0_0001;
               state <= GDL_CTL_HS_ON;
            end
            GDL_CTL_HS_ON: begin
               if (count == 20'h0_0000 && all_hs == 3'b000) begin
                  link.phase_a_high_side_input_n <= 1'b1;
                  link.phase_b_high_side_input_n <= 1'b1;
                  link.phase_c_high_side_input_n <= 1'b1;
                  state <= GDL_CTL_HS_OFF;
               end
            end
            GDL_CTL_HS_OFF: begin
               busy <= 1'b0;
               ready <= 1'b1;
               state <= GDL_CTL_IDLE;
            end
            default: begin
               state <= GDL_CTL_IDLE;
            end
         endcase
      end
   end

endmodule : gdl_ctl

// *** gdl_link_chk.sv ***
// Checker of the pin level link between the controller end and the pre-driver end
`include "gdl_params.svh"

module gdl_link_chk #(
   parameter int WAKE_CYC = `GDL_EN_TO_LS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reset_input_n,
   input wire logic enable_input_one,
   input wire logic enable_input_two,
   input wire logic phase_a_low_side_input,
   input wire logic phase_b_low_side_input,
   input wire logic phase_c_low_side_input,
   input wire logic phase_a_high_side_input_n,
   input wire logic phase_b_high_side_input_n,
   input wire logic phase_c_high_side_input_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd,
   input wire logic [7:0] resp
);
   logic en;
   logic [2:0] ls;
   logic [2:0] hs_n;
   logic [7:0] en_cnt;
   logic [7:0] ls_cnt;
   logic [7:0] hs_cnt;
   logic clr_seen;
   logic dead_seen;
   assign en = enable_input_one & enable_input_two;
   assign ls = {phase_c_low_side_input, phase_b_low_side_input, phase_a_low_side_input};
   assign hs_n = {phase_c_high_side_input_n, phase_b_high_side_input_n, phase_a_high_side_input_n};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Saturating run lengths of enables high, low sides on and high sides on
   always_ff @(posedge clk) begin
      en_cnt <= (!rst_n || !en) ? 8'h00 : en_cnt + {7'h00, en_cnt != 8'hFF};
      ls_cnt <= (!rst_n || ls != 3'h7) ? 8'h00 : ls_cnt + {7'h00, ls_cnt != 8'hFF};
      hs_cnt <= (!rst_n || hs_n != 3'h0) ? 8'h00 : hs_cnt + {7'h00, hs_cnt != 8'hFF};
   end
   always_ff @(posedge clk) begin
      if (!rst_n || !reset_input_n) begin
         dead_seen <= 1'b0;
      end else if (cmd_valid && cmd[7:1] == 7'h40) begin
         dead_seen <= 1'b1;
      end
      if (!rst_n || $fell(en)) begin
         clr_seen <= 1'b0;
      end else if (cmd_valid && cmd == `GDL_CMD_CLEAR_INT_1) begin
         clr_seen <= 1'b1;
      end
   end
   ls_after_wake_a: assert property ($rose(ls[0]) |-> en_cnt >= WAKE_CYC)
      else $error("low side rose too soon after enables");
   ls_pulse_width_a: assert property ($fell(ls[0]) |-> ls_cnt >= 8'h19)
      else $error("low side pulse too short");
   hs_pulse_width_a: assert property ($rose(hs_n[0]) |-> hs_cnt >= 8'h32)
      else $error("high side low period too short");
   hs_set_first_a: assert property ($rose(ls[0]) |-> hs_n == 3'h7 && en)
      else $error("low side rose without high sides off");
   hs_after_ls_a: assert property ($fell(hs_n[0]) |-> ls == 3'h0 && hs_n == 3'h0)
      else $error("high side toggle not after low side or not together");
   clear_first_a: assert property ($rose(en) |-> clr_seen)
      else $error("enables rose before clear commands");
   dead_first_a: assert property ($rose(en) |-> dead_seen)
      else $error("enables rose before dead time set");
   power_up_a: assert property ($rose(reset_input_n) |-> !enable_input_one && !enable_input_two)
      else $error("reset released with enables high");
   resp_next_a: assert property (!$stable(resp) |-> $past(cmd_valid))
      else $error("answer changed without a command");
   cover property ($fell(ls[0]));
   cover property ($rose(en));
   cover property (cmd_valid && cmd == `GDL_CMD_CLEAR_INT_0);
endmodule : gdl_link_chk

// *** test_gate_drive_lockout_init.sv ***
// Self-checking bench joining the controller end and the pre-driver end
`include "gdl_params.svh"

module test_gate_drive_lockout_init;
   timeunit 1ns;
   timeprecision 1ps;
   import gdl_pkg::*;
   logic clk;
   logic rst_n;
   logic [3:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic fault;
   gdl_phase_type ls_g, hs_g, short_g, locked, tied;
   logic rec, pump, sup, rec_seen, pump_cfg;
   logic [31:0] q;
   int n_fail = 0;
   int checks_done = 0;
   gdl_link_if lk();
   gdl_dev #(.POWER_UP_CYC(20), .WAKE_CYC(4)) gdl_dev_inst (.clk(clk), .rst_n(rst_n),
      .link(lk.dev), .fault(fault), .tied_mode(tied), .pump_configured(pump_cfg),
      .low_side_gate(ls_g), .high_side_gate(hs_g), .gate_source_short(short_g),
      .high_side_locked(locked), .recirculation(rec), .charge_pump_on(pump),
      .supplies_ready(sup));
   gdl_ctl #(.POWER_UP_CYC(20), .WAKE_CYC(4)) gdl_ctl_inst (.clk(clk), .rst_n(rst_n),
      .link(lk.ctl), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   gdl_link_chk #(.WAKE_CYC(4)) gdl_link_chk_inst (.clk(clk), .rst_n(rst_n),
      .reset_input_n(lk.reset_input_n), .enable_input_one(lk.enable_input_one),
      .enable_input_two(lk.enable_input_two), .phase_a_low_side_input(lk.phase_a_low_side_input),
      .phase_b_low_side_input(lk.phase_b_low_side_input),
      .phase_c_low_side_input(lk.phase_c_low_side_input),
      .phase_a_high_side_input_n(lk.phase_a_high_side_input_n),
      .phase_b_high_side_input_n(lk.phase_b_high_side_input_n),
      .phase_c_high_side_input_n(lk.phase_c_high_side_input_n),
      .cmd_valid(lk.cmd_valid), .cmd(lk.cmd), .resp(lk.resp));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= we;
      rd <= !we;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 q = rdata;
   endtask : bus
   // Starts a sequence and polls status until busy drops, noting recirculation
   task automatic run(input logic [31:0] ctrl);
      rec_seen = 1'b0;
      bus(1'b1, `GDL_REG_CTRL, ctrl);
      for (int i = 0; i < 300; i++) begin
         bus(1'b0, `GDL_REG_STATUS, 32'h0);
         rec_seen |= rec;
         if (q[0] === 1'b0) break;
      end
   endtask : run
   task automatic t_regs;
      bus(1'b0, `GDL_REG_CFG, 32'h0);
      check(q, `GDL_CFG_RESET);
      bus(1'b1, 4'hC, 32'hFFFF_FFFF);
      bus(1'b0, 4'hC, 32'h0);
      check(q, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_init;
      run(32'h1);
      check(q[1:0], 2'h2);
      check(locked, 3'h0);
      check(short_g, 3'h7);
      check(hs_g, 3'h0);
      check(ls_g, 3'h0);
      check(rec_seen, 1'b1);
      check({pump, sup}, 2'h3);
      $display("test init done");
   endtask : t_init
   task automatic t_fault;
      @(posedge clk);
      fault <= 1'b1;
      repeat (4) @(posedge clk);
      check({ls_g, hs_g, locked}, 9'h007);
      fault <= 1'b0;
      repeat (40) @(posedge clk);
      run(32'h2);
      check({q[1:0], locked}, 5'h10);
      check(q, 32'h009F_0106);
      $display("test fault done");
   endtask : t_fault
   task automatic t_standby;
      run(32'h4);
      repeat (4) @(posedge clk);
      check({lk.enable_input_one, lk.enable_input_two}, 2'h0);
      check({ls_g, hs_g, locked}, 9'h007);
      run(32'h2);
      check({q[1:0], locked, short_g}, 8'h87);
      $display("test standby done");
   endtask : t_standby
   task automatic t_tied;
      @(posedge clk);
      tied <= 3'h1;
      pump_cfg <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({hs_g, short_g, pump}, 7'h1C);
      $display("test tied done");
   endtask : t_tied
   task automatic results;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   initial begin
      rst_n = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      fault = 1'b0;
      tied = 3'h0;
      pump_cfg = 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_init();
      t_fault();
      t_standby();
      t_tied();
      results();
   end
   initial begin
      #40000;
      n_fail++;
      results();
   end
endmodule : test_gate_drive_lockout_init
